/* File: pkg/acrf_params.svh */
`ifndef ACRF_PARAMS_SVH
`define ACRF_PARAMS_SVH

// register offsets
`define ACRF_OFS_RESULT_LOW  8'h78
`define ACRF_OFS_RESULT_HIGH 8'h79
`define ACRF_OFS_SELECT      8'h7c
`define ACRF_OFS_IRQ_STATUS  8'h7d
`define ACRF_OFS_IRQ_MASK    8'h7e

// channel_reference_select fields and reset value
`define ACRF_SELECT_RST      8'h00
`define ACRF_REF_MSB         7
`define ACRF_REF_LSB         6
`define ACRF_LJ_BIT          5
`define ACRF_CH_MSB          4
`define ACRF_CH_LSB          0

// reference_select_field codes
`define ACRF_REF_EXT         2'h0
`define ACRF_REF_SUPPLY      2'h1
`define ACRF_REF_RSVD        2'h2
`define ACRF_REF_INT         2'h3

// channel_select_field codes
`define ACRF_CH_SE_LAST      5'h07
`define ACRF_CH_DIFF_FIRST   5'h10
`define ACRF_CH_DIFF_N1_LAST 5'h17
`define ACRF_CH_DIFF_N2_LAST 5'h1d
`define ACRF_CH_BANDGAP      5'h1e
`define ACRF_CH_GROUND       5'h1f

// result coding
`define ACRF_RES_W           10
`define ACRF_RAW_W           11
`define ACRF_RES_RST         10'h000
`define ACRF_SE_MAX          10'h3ff
`define ACRF_DIFF_MAX        10'h1ff
`define ACRF_DIFF_MIN        10'h200

// interrupt status / mask layout
`define ACRF_IRQ_W           2
`define ACRF_IRQ_RST         2'h0
`define ACRF_IRQ_DONE_BIT    0
`define ACRF_IRQ_DROP_BIT    1

`endif

/* File: pkg/acrf_pkg.sv */
package acrf_pkg;

  typedef enum logic [1:0] {
    ACRF_ST_IDLE = 2'b01,
    ACRF_ST_BUSY = 2'b10
  } acrf_state_t;

endpackage

/* File: core/acrf_result_format.sv */
`timescale 1ns/10ps
`include "acrf_params.svh"

module acrf_result_format (
  // held result and presentation
  input  wire logic [`ACRF_RES_W-1:0] result_i,
  input  wire logic                   left_justify_i,
  // register views
  output logic      [7:0]             low_o,
  output logic      [7:0]             high_o
);

  always_comb begin
    if (left_justify_i) begin
      high_o = result_i[`ACRF_RES_W-1:2];
      low_o  = {result_i[1:0], 6'h00};
    end else begin
      high_o = {6'h00, result_i[`ACRF_RES_W-1:8]};
      low_o  = result_i[7:0];
    end
  end

endmodule

/* File: core/acrf_top.sv */
// How it works
// - after completion, the result stands in the low and high result registers.
// - single-ended code is vin*1024/vref, clamped to 0x3ff at the top.
// - differential code is 10-bit two's complement, clamped to 0x200..0x1ff.
// - bits 7:6 pick external pin, analog supply, reserved, or internal 1.1V reference.
// - reference or channel writes during a conversion wait for its completion.
// - bit 5 set gives left-justified result, clear gives right-justified.
// - changing bit 5 reformats the held result at once, even mid-conversion.
// - codes 0-7 single-ended inputs, 8-15 unused, 0x1e bandgap, 0x1f ground.
// - 0x10-0x17 inputs 0-7 against input 1; 0x18-0x1d inputs 0-5 against 2.
// - completion flag sets when a conversion ends and the result updates.
// - after a low read, result registers hold until the high register is read.
// - reset gives right justification; layouts place bits 9:8/7:0 or 9:2/1:0.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`include "acrf_params.svh"

module acrf_top (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   arst_n_i,
  // register port
  input  wire logic [7:0]             addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [7:0]             rdata_o,
  // converter core
  input  wire logic                   conv_start_i,
  input  wire logic                   conv_done_i,
  input  wire logic [`ACRF_RAW_W-1:0] conv_data_i,
  output logic                        busy_o,
  // reference steering
  output logic      [1:0]             ref_sel_o,
  output logic                        ext_ref_sel_o,
  output logic                        supply_ref_sel_o,
  output logic                        int_ref_en_o,
  // input multiplexer steering
  output logic      [7:0]             pos_sel_o,
  output logic      [1:0]             neg_sel_o,
  output logic                        bandgap_sel_o,
  output logic                        ground_sel_o,
  output logic                        diff_mode_o,
  // interrupt
  output logic                        irq_o
);

  acrf_pkg::acrf_state_t state_reg, state_next;

  logic [7:0]             sel_reg, sel_next;
  logic [1:0]             act_ref_reg, act_ref_next;
  logic [4:0]             act_ch_reg, act_ch_next;
  logic [2:0]             refsrc_reg, refsrc_next;
  logic [`ACRF_RES_W-1:0] result_reg, result_next;
  logic                   lock_reg, lock_next;
  logic [`ACRF_IRQ_W-1:0] status_reg, status_next;
  logic [`ACRF_IRQ_W-1:0] mask_reg, mask_next;
  logic [7:0]             rdata_reg, rdata_next;
  logic                   irq_reg, irq_next;
  logic [7:0]             pos_sel_reg, pos_sel_next;
  logic [1:0]             neg_sel_reg, neg_sel_next;
  logic                   bg_reg, bg_next;
  logic                   gnd_reg, gnd_next;
  logic                   diff_reg, diff_next;

  logic                   rd_low, rd_high, rd_status, rd_mask;
  logic                   wr_select, wr_mask;
  logic                   finish, lock_eff;
  logic                   act_is_diff;
  logic [`ACRF_RES_W-1:0] coded;
  logic [`ACRF_IRQ_W-1:0] set_bits;
  logic [7:0]             fmt_low, fmt_high;

  // decode of the register port
  always_comb begin
    rd_low    = rd_i && (addr_i == `ACRF_OFS_RESULT_LOW);
    rd_high   = rd_i && (addr_i == `ACRF_OFS_RESULT_HIGH);
    rd_status = rd_i && (addr_i == `ACRF_OFS_IRQ_STATUS);
    rd_mask   = rd_i && (addr_i == `ACRF_OFS_IRQ_MASK);
    wr_select = wr_i && (addr_i == `ACRF_OFS_SELECT);
    wr_mask   = wr_i && (addr_i == `ACRF_OFS_IRQ_MASK);
  end

  // conversion state
  always_comb begin
    state_next = state_reg;
    finish     = 1'b0;
    case (state_reg)
      acrf_pkg::ACRF_ST_IDLE: begin
        if (conv_start_i) begin
          state_next = acrf_pkg::ACRF_ST_BUSY;
        end
      end
      acrf_pkg::ACRF_ST_BUSY: begin
        if (conv_done_i) begin
          finish     = 1'b1;
          state_next = acrf_pkg::ACRF_ST_IDLE;
        end
      end
      default: begin
        state_next = acrf_pkg::ACRF_ST_IDLE;
      end
    endcase
  end

  // software copy and active copy of the selection
  always_comb begin
    sel_next     = wr_select ? wdata_i : sel_reg;
    act_ref_next = act_ref_reg;
    act_ch_next  = act_ch_reg;
    // idle or finishing: the copy follows the register, so a write made mid-conversion
    // lands only at completion
    if (state_reg != acrf_pkg::ACRF_ST_BUSY || finish) begin
      act_ref_next = sel_next[`ACRF_REF_MSB:`ACRF_REF_LSB];
      act_ch_next  = sel_next[`ACRF_CH_MSB:`ACRF_CH_LSB];
    end
    // source enables registered so the reference pins never glitch on a decode
    refsrc_next = {(act_ref_next == `ACRF_REF_EXT), (act_ref_next == `ACRF_REF_SUPPLY),
                   (act_ref_next == `ACRF_REF_INT)};
  end

  // result coding from the raw core word
  always_comb begin
    act_is_diff = (act_ch_reg >= `ACRF_CH_DIFF_FIRST) && (act_ch_reg <= `ACRF_CH_DIFF_N2_LAST);
    if (act_is_diff) begin
      // signed raw word: an overflow shows as bit 10 differing from bit 9
      if (!conv_data_i[`ACRF_RAW_W-1] && conv_data_i[`ACRF_RES_W-1]) begin
        coded = `ACRF_DIFF_MAX;
      end else if (conv_data_i[`ACRF_RAW_W-1] && !conv_data_i[`ACRF_RES_W-1]) begin
        coded = `ACRF_DIFF_MIN;
      end else begin
        coded = conv_data_i[`ACRF_RES_W-1:0];
      end
    end else if (conv_data_i[`ACRF_RAW_W-1]) begin
      coded = `ACRF_SE_MAX;
    end else begin
      coded = conv_data_i[`ACRF_RES_W-1:0];
    end
  end

  // held result and read interlock
  always_comb begin
    // a low read in the same cycle as a completion already counts as locking,
    // otherwise the high half would belong to the newer result
    lock_eff    = lock_reg || rd_low;
    result_next = result_reg;
    lock_next   = lock_reg;
    set_bits    = `ACRF_IRQ_RST;
    if (rd_low) begin
      lock_next = 1'b1;
    end
    if (rd_high) begin
      lock_next = 1'b0;
    end
    if (finish) begin
      if (!lock_eff) begin
        result_next                  = coded;
        set_bits[`ACRF_IRQ_DONE_BIT] = 1'b1;
      end else begin
        // no second buffer: a result arriving while locked is lost and flagged
        set_bits[`ACRF_IRQ_DROP_BIT] = 1'b1;
      end
    end
  end

  // live presentation, left_justify_bit taken straight from the register
  acrf_result_format u_format (
    .result_i       (result_reg),
    .left_justify_i (sel_reg[`ACRF_LJ_BIT]),
    .low_o          (fmt_low),
    .high_o         (fmt_high)
  );

  // status, mask, interrupt and read data
  always_comb begin
    status_next = (rd_status ? `ACRF_IRQ_RST : status_reg) | set_bits;
    mask_next   = wr_mask ? wdata_i[`ACRF_IRQ_W-1:0] : mask_reg;
    irq_next    = |(status_next & mask_next);
    rdata_next  = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `ACRF_OFS_RESULT_LOW:  rdata_next = fmt_low;
        `ACRF_OFS_RESULT_HIGH: rdata_next = fmt_high;
        `ACRF_OFS_SELECT:      rdata_next = sel_reg;
        `ACRF_OFS_IRQ_STATUS:  rdata_next = {{(8-`ACRF_IRQ_W){1'b0}}, status_reg};
        `ACRF_OFS_IRQ_MASK:    rdata_next = {{(8-`ACRF_IRQ_W){1'b0}}, mask_reg};
        default:               rdata_next = 8'h00;
      endcase
    end
  end

  // multiplexer steering from the next active channel, so it lines up with the copy
  always_comb begin
    pos_sel_next = 8'h00;
    neg_sel_next = 2'h0;
    bg_next      = 1'b0;
    gnd_next     = 1'b0;
    diff_next    = 1'b0;
    if (act_ch_next <= `ACRF_CH_SE_LAST) begin
      pos_sel_next[act_ch_next[2:0]] = 1'b1;
    end else if (act_ch_next >= `ACRF_CH_DIFF_FIRST && act_ch_next <= `ACRF_CH_DIFF_N1_LAST) begin
      pos_sel_next[act_ch_next[2:0]] = 1'b1;
      neg_sel_next[0]                = 1'b1;
      diff_next                      = 1'b1;
    end else if (act_ch_next > `ACRF_CH_DIFF_N1_LAST && act_ch_next <= `ACRF_CH_DIFF_N2_LAST) begin
      pos_sel_next[act_ch_next[2:0]] = 1'b1;
      neg_sel_next[1]                = 1'b1;
      diff_next                      = 1'b1;
    end else if (act_ch_next == `ACRF_CH_BANDGAP) begin
      bg_next = 1'b1;
    end else if (act_ch_next == `ACRF_CH_GROUND) begin
      gnd_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg   <= acrf_pkg::ACRF_ST_IDLE;
      sel_reg     <= `ACRF_SELECT_RST;
      act_ref_reg <= `ACRF_REF_EXT;
      act_ch_reg  <= 5'h00;
      refsrc_reg  <= 3'h4;
      result_reg  <= `ACRF_RES_RST;
      lock_reg    <= 1'b0;
      status_reg  <= `ACRF_IRQ_RST;
      mask_reg    <= `ACRF_IRQ_RST;
      rdata_reg   <= 8'h00;
      irq_reg     <= 1'b0;
      pos_sel_reg <= 8'h01;
      neg_sel_reg <= 2'h0;
      bg_reg      <= 1'b0;
      gnd_reg     <= 1'b0;
      diff_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      sel_reg     <= sel_next;
      act_ref_reg <= act_ref_next;
      act_ch_reg  <= act_ch_next;
      refsrc_reg  <= refsrc_next;
      result_reg  <= result_next;
      lock_reg    <= lock_next;
      status_reg  <= status_next;
      mask_reg    <= mask_next;
      rdata_reg   <= rdata_next;
      irq_reg     <= irq_next;
      pos_sel_reg <= pos_sel_next;
      neg_sel_reg <= neg_sel_next;
      bg_reg      <= bg_next;
      gnd_reg     <= gnd_next;
      diff_reg    <= diff_next;
    end
  end

  // reference steering; the reserved code drives no source at all
  always_comb begin
    ref_sel_o        = act_ref_reg;
    ext_ref_sel_o    = refsrc_reg[2];
    supply_ref_sel_o = refsrc_reg[1];
    int_ref_en_o     = refsrc_reg[0];
  end

  assign rdata_o       = rdata_reg;
  assign busy_o        = (state_reg == acrf_pkg::ACRF_ST_BUSY);
  assign pos_sel_o     = pos_sel_reg;
  assign neg_sel_o     = neg_sel_reg;
  assign bandgap_sel_o = bg_reg;
  assign ground_sel_o  = gnd_reg;
  assign diff_mode_o   = diff_reg;
  assign irq_o         = irq_reg;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_done_updates;
    finish && !lock_eff |=> status_reg[`ACRF_IRQ_DONE_BIT] && (result_reg == $past(coded));
  endproperty
  a_done_updates: assert property (p_done_updates) else $error("result or flag not updated");

  property p_se_clamp;
    finish && !lock_eff && !act_is_diff && conv_data_i[`ACRF_RAW_W-1]
      |=> result_reg == `ACRF_SE_MAX;
  endproperty
  a_se_clamp: assert property (p_se_clamp) else $error("single-ended clamp wrong");

  property p_diff_pos;
    finish && !lock_eff && act_is_diff && !conv_data_i[`ACRF_RAW_W-1]
      && conv_data_i[`ACRF_RES_W-1] |=> result_reg == `ACRF_DIFF_MAX;
  endproperty
  a_diff_pos: assert property (p_diff_pos) else $error("positive clamp wrong");

  property p_diff_neg;
    finish && !lock_eff && act_is_diff && conv_data_i[`ACRF_RAW_W-1]
      && !conv_data_i[`ACRF_RES_W-1] |=> result_reg == `ACRF_DIFF_MIN;
  endproperty
  a_diff_neg: assert property (p_diff_neg) else $error("negative clamp wrong");

  property p_hold_busy;
    busy_o && !conv_done_i |=> $stable(act_ref_reg) && $stable(act_ch_reg);
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("selection moved mid-conversion");

  property p_idle_follow;
    !busy_o && wr_select |=> act_ch_reg == $past(wdata_i[`ACRF_CH_MSB:`ACRF_CH_LSB])
      && act_ref_reg == $past(wdata_i[`ACRF_REF_MSB:`ACRF_REF_LSB]);
  endproperty
  a_idle_follow: assert property (p_idle_follow) else $error("active copy not loaded");

  property p_lock_hold;
    lock_reg && !rd_high |=> $stable(result_reg);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("result changed while locked");

  property p_left_high;
    rd_high && sel_reg[`ACRF_LJ_BIT]
      |=> rdata_o == $past(result_reg[`ACRF_RES_W-1:2]);
  endproperty
  a_left_high: assert property (p_left_high) else $error("left-justified high wrong");

  property p_right_low;
    rd_low && !sel_reg[`ACRF_LJ_BIT] |=> rdata_o == $past(result_reg[7:0]);
  endproperty
  a_right_low: assert property (p_right_low) else $error("right-justified low wrong");

  property p_lj_live;
    busy_o && rd_low && sel_reg[`ACRF_LJ_BIT]
      |=> rdata_o[7:6] == $past(result_reg[1:0]) && rdata_o[5:0] == 6'h00;
  endproperty
  a_lj_live: assert property (p_lj_live) else $error("left adjust not live");

  property p_diff_steer;
    diff_mode_o |-> $onehot(neg_sel_o) && $onehot(pos_sel_o) && !bandgap_sel_o;
  endproperty
  a_diff_steer: assert property (p_diff_steer) else $error("differential steering wrong");

  property p_bg_steer;
    bandgap_sel_o |-> act_ch_reg == `ACRF_CH_BANDGAP && pos_sel_o == 8'h00;
  endproperty
  a_bg_steer: assert property (p_bg_steer) else $error("bandgap steering wrong");

  property p_irq_level;
    irq_o == |(status_reg & mask_reg);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_result_view;
    finish && !lock_eff ##1 rd_low |=> rdata_o == ($past(sel_reg[`ACRF_LJ_BIT]) ?
      {$past(result_reg[1:0]), 6'h00} : $past(result_reg[7:0]));
  endproperty
  a_result_view: assert property (p_result_view) else $error("result not presented");

  c_done:    cover property (finish && !lock_eff);
  c_drop:    cover property (finish && lock_reg);
  c_lj_read: cover property (rd_high && sel_reg[`ACRF_LJ_BIT]);
  c_defer:   cover property (busy_o && wr_select ##[1:20] finish);

endmodule

/* File: verif/acrf_core_model.sv */
`timescale 1ns/10ps

module acrf_core_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // bench control
  input  wire logic        go_i,
  input  wire logic [10:0] raw_i,
  input  wire logic [3:0]  lat_i,
  // converter handshake
  input  wire logic        busy_i,
  output logic             conv_start_o,
  output logic             conv_done_o,
  output logic      [10:0] conv_data_o
);
  logic [3:0] cnt_reg;

  // data is valid only beside done; elsewhere it shows the inverse so an
  // early sample picks up a wrong code
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_start_o <= 1'b0;
      conv_done_o  <= 1'b0;
      conv_data_o  <= 11'h7ff;
      cnt_reg      <= 4'h0;
    end else begin
      conv_start_o <= go_i;
      conv_done_o  <= 1'b0;
      conv_data_o  <= ~raw_i;
      if (conv_start_o) begin
        cnt_reg <= lat_i;
      end else if (busy_i && cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          conv_done_o <= 1'b1;
          conv_data_o <= raw_i;
        end
      end
    end
  end
endmodule

/* File: verif/test_acrf_top.sv */
`timescale 1ns/10ps
`include "acrf_params.svh"

module test_acrf_top;
  logic        clk_i    = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [7:0]  addr_i   = 8'h00;
  logic [7:0]  wdata_i  = 8'h00;
  logic        wr_i     = 1'b0;
  logic        rd_i     = 1'b0;
  logic        go       = 1'b0;
  logic [10:0] raw      = 11'h000;
  logic [3:0]  lat      = 4'h2;
  logic [7:0]  rdata_o, pos_sel_o, d;
  logic [10:0] conv_data;
  logic [1:0]  ref_sel_o, neg_sel_o;
  logic        conv_start, conv_done, busy_o, ext_ref_sel_o, supply_ref_sel_o;
  logic        int_ref_en_o, bandgap_sel_o, ground_sel_o, diff_mode_o, irq_o;
  logic [15:0] m;
  logic [10:0] tab_raw [4] = '{11'h200, 11'h5ff, 11'h7ff, 11'h7a3};
  logic [9:0]  tab_res [4] = '{10'h1ff, 10'h200, 10'h3ff, 10'h3a3};
  int          n_fail = 0;
  int          checks = 0;

  always #2 clk_i = ~clk_i;

  acrf_top i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_start_i(conv_start),
    .conv_done_i(conv_done), .conv_data_i(conv_data), .busy_o(busy_o),
    .ref_sel_o(ref_sel_o), .ext_ref_sel_o(ext_ref_sel_o), .supply_ref_sel_o(supply_ref_sel_o),
    .int_ref_en_o(int_ref_en_o), .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o),
    .bandgap_sel_o(bandgap_sel_o), .ground_sel_o(ground_sel_o), .diff_mode_o(diff_mode_o),
    .irq_o(irq_o));

  acrf_core_model i_core (.clk_i(clk_i), .arst_n_i(arst_n_i), .go_i(go), .raw_i(raw),
    .lat_i(lat), .busy_i(busy_o), .conv_start_o(conv_start), .conv_done_o(conv_done),
    .conv_data_o(conv_data));

  task automatic summarize();
    $display("counts: checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
  endtask

  task automatic chk_rd(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(n, e, v);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_busy(input logic v);
    for (int i = 0; i < 40; i++) begin
      if (busy_o === v) return;
      @(posedge clk_i);
      #1;
    end
    n_fail++;
    summarize();
  endtask

  task automatic conv(input logic [10:0] r, input logic [3:0] l, input logic wait_end);
    @(posedge clk_i);
    raw <= r;
    lat <= l;
    go  <= 1'b1;
    @(posedge clk_i);
    go  <= 1'b0;
    wait_busy(1'b1);
    if (wait_end) wait_busy(1'b0);
  endtask

  function automatic logic [7:0] ref_exp(input logic [1:0] r);
    return {3'b000, r, r == 2'h0, r == 2'h1, r == 2'h3};
  endfunction

  function automatic logic [7:0] ref_now();
    return {3'b000, ref_sel_o, ext_ref_sel_o, supply_ref_sel_o, int_ref_en_o};
  endfunction

  // {positive one-hot, 3'b0, negative, bandgap, ground, differential}
  function automatic logic [15:0] mux_exp(input logic [4:0] c);
    if (c <= `ACRF_CH_SE_LAST) return {8'h01 << c, 8'h00};
    if (c >= `ACRF_CH_DIFF_FIRST && c <= `ACRF_CH_DIFF_N1_LAST)
      return {8'h01 << (c - 5'h10), 8'h09};
    if (c >= 5'h18 && c <= `ACRF_CH_DIFF_N2_LAST) return {8'h01 << (c - 5'h18), 8'h11};
    if (c == `ACRF_CH_BANDGAP) return {8'h00, 8'h04};
    if (c == `ACRF_CH_GROUND) return {8'h00, 8'h02};
    return 16'h0000;
  endfunction

  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    chk_rd("select", `ACRF_OFS_SELECT, `ACRF_SELECT_RST);
    chk_rd("res_low", `ACRF_OFS_RESULT_LOW, 8'h00);
    chk_rd("res_high", `ACRF_OFS_RESULT_HIGH, 8'h00);
    chk("ref", ref_exp(2'h0), ref_now());
    chk("pos", 8'h01, pos_sel_o);
    wr(8'h7f, 8'hff);
    chk_rd("unmapped", 8'h7f, 8'h00);
    $display("test reset done");

    for (int r = 0; r < 4; r++) begin
      wr(`ACRF_OFS_SELECT, {r[1:0], 6'h00});
      settle();
      chk("ref", ref_exp(r[1:0]), ref_now());
      chk_rd("select", `ACRF_OFS_SELECT, {r[1:0], 6'h00});
    end
    for (int c = 0; c < 32; c++) begin
      wr(`ACRF_OFS_SELECT, {3'b010, c[4:0]});
      settle();
      m = mux_exp(c[4:0]);
      chk("pos", m[15:8], pos_sel_o);
      chk("mux", m[7:0], {3'b000, neg_sel_o, bandgap_sel_o, ground_sel_o, diff_mode_o});
    end
    $display("test selection done");

    wr(`ACRF_OFS_IRQ_MASK, 8'h00);
    wr(`ACRF_OFS_SELECT, 8'h40);
    conv(11'h155, 4'h3, 1'b1);
    chk_rd("res_low", `ACRF_OFS_RESULT_LOW, 8'h55);
    chk_rd("res_high", `ACRF_OFS_RESULT_HIGH, 8'h01);
    chk("irq", 8'h00, {7'h00, irq_o});
    wr(`ACRF_OFS_IRQ_MASK, 8'h01);
    settle();
    chk("irq", 8'h01, {7'h00, irq_o});
    chk_rd("status", `ACRF_OFS_IRQ_STATUS, 8'h01);
    @(posedge clk_i);
    #1;
    chk("irq", 8'h00, {7'h00, irq_o});
    conv(11'h400, 4'h1, 1'b1);
    @(posedge clk_i);
    #1;
    chk("irq", 8'h01, {7'h00, irq_o});
    chk_rd("status", `ACRF_OFS_IRQ_STATUS, 8'h01);
    chk_rd("res_low", `ACRF_OFS_RESULT_LOW, 8'hff);
    chk_rd("res_high", `ACRF_OFS_RESULT_HIGH, 8'h03);
    $display("test single-ended done");

    wr(`ACRF_OFS_SELECT, 8'hdb);
    for (int k = 0; k < 4; k++) begin
      conv(tab_raw[k], 4'h2, 1'b1);
      chk_rd("res_low", `ACRF_OFS_RESULT_LOW, tab_res[k][7:0]);
      chk_rd("res_high", `ACRF_OFS_RESULT_HIGH, {6'h00, tab_res[k][9:8]});
    end
    wr(`ACRF_OFS_SELECT, 8'hfb);
    chk_rd("res_low", `ACRF_OFS_RESULT_LOW, 8'hc0);
    chk_rd("res_high", `ACRF_OFS_RESULT_HIGH, 8'he8);
    $display("test differential done");

    wr(`ACRF_OFS_SELECT, 8'h40);
    settle();
    conv(11'h0aa, 4'hc, 1'b0);
    wr(`ACRF_OFS_SELECT, 8'he5);
    settle();
    chk("ref", ref_exp(2'h1), ref_now());
    chk("pos", 8'h01, pos_sel_o);
    chk_rd("res_low", `ACRF_OFS_RESULT_LOW, 8'hc0);
    chk_rd("res_high", `ACRF_OFS_RESULT_HIGH, 8'he8);
    wait_busy(1'b0);
    settle();
    chk("ref", ref_exp(2'h3), ref_now());
    chk("pos", 8'h20, pos_sel_o);
    $display("test deferral done");

    rd(`ACRF_OFS_IRQ_STATUS, d);
    chk_rd("res_low", `ACRF_OFS_RESULT_LOW, 8'h80);
    conv(11'h3ff, 4'h1, 1'b1);
    chk_rd("res_high", `ACRF_OFS_RESULT_HIGH, 8'h2a);
    chk_rd("status", `ACRF_OFS_IRQ_STATUS, 8'h02);
    chk_rd("res_low", `ACRF_OFS_RESULT_LOW, 8'h80);
    chk_rd("res_high", `ACRF_OFS_RESULT_HIGH, 8'h2a);
    $display("test result lock done");
    summarize();
  end
endmodule
